// *** hdl/ahw_pkg.sv ***
// Purpose: constants, types and helpers for the cell health word block
// Assumes: 32-bit AXI4-Lite register bus, one clock domain
// Notes:   byte offsets are word aligned
package ahw_pkg;

	localparam int unsigned AXI_AW = 5;

	localparam logic [4:0] ADDR_HEALTH = 5'h00;
	localparam logic [4:0] ADDR_CTRL   = 5'h04;
	localparam logic [4:0] ADDR_STAT   = 5'h08;
	localparam logic [4:0] ADDR_MASK   = 5'h0C;
	localparam logic [4:0] ADDR_FILT   = 5'h10;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam int unsigned HB_SS_LSB = 0;
	localparam int unsigned HB_SS_MSB = 3;
	localparam int unsigned HB_SYNC   = 4;
	localparam int unsigned HB_PLL    = 5;
	localparam int unsigned HB_DET    = 6;
	localparam int unsigned HB_CHOP   = 7;
	localparam int unsigned HB_DP     = 8;
	localparam int unsigned HB_REF    = 9;
	localparam int unsigned HB_TIN    = 10;
	localparam int unsigned HB_TOUT   = 11;
	localparam int unsigned HB_HEAD   = 12;
	localparam int unsigned HB_UNUSED_LSB = 13;

	localparam logic [15:0] HEALTH_MAX = 16'h1FFF;
	localparam logic [15:0] HEALTH_RST = 16'h0010;
	// every ok flag of the word, used to spot a degraded record
	localparam logic [15:0] HEALTH_OK_MASK = 16'h1FE0;

	typedef enum logic [1:0] {
		AHW_BW_5  = 2'h0,
		AHW_BW_10 = 2'h1,
		AHW_BW_20 = 2'h2
	} ahw_bw_t;
	localparam ahw_bw_t BW_RST = AHW_BW_20;

	localparam int unsigned BW5_SHIFT  = 3;
	localparam int unsigned BW10_SHIFT = 2;
	localparam int unsigned BW20_SHIFT = 1;

	localparam int SS_SCALE     = 100;
	localparam int SS_STEP_X100 = 667;
	localparam int SS_NIB_MAX   = 15;

	localparam int DP_MIN_MV = 100;
	localparam int DP_MAX_MV = 4900;

	localparam int unsigned IRQ_REC    = 0;
	localparam int unsigned IRQ_FAULT  = 1;
	localparam int unsigned IRQ_UNLOCK = 2;
	localparam int unsigned IRQ_W      = 3;

	function automatic logic [3:0] ahw_ss_nibble(input logic [6:0] ss);
		int prod;
		logic [3:0] n;
		prod = int'(ss) * SS_SCALE;
		n = 4'h0;
		for (int k = 1; k <= SS_NIB_MAX; k++)
			if (prod >= k * SS_STEP_X100)
				n = 4'(k);
		return n;
	endfunction : ahw_ss_nibble

	function automatic logic ahw_near(input logic signed [11:0] err,
		input int tol);
		int mag;
		mag = (err < 0) ? -int'(err) : int'(err);
		return mag <= tol;
	endfunction : ahw_near

endpackage : ahw_pkg

// *** hdl/ahw_src_if.sv ***
// Purpose: carries the quantized status sources to the word assembler
// Assumes: producer registers every field
// Notes:   none
`timescale 1ns/1ns
interface ahw_src_if;
	logic [3:0] ss_nibble;
	logic       dp_ok;
	logic       det_ok;
	logic       chop_ok;
	modport prod (output ss_nibble, output dp_ok, output det_ok,
		output chop_ok);
	modport cons (input ss_nibble, input dp_ok, input det_ok,
		input chop_ok);
endinterface : ahw_src_if

// *** hdl/ahw_quant.sv ***
// Purpose: quantizes signal strength and checks analog sources
// Assumes: inputs synchronous to sys_clk
// Notes:   one cycle of latency on every field
`timescale 1ns/1ns
module ahw_quant
	import ahw_pkg::*;
#(
	parameter int DET_TOL  = 50,
	parameter int CHOP_TOL = 50
)(
	input  wire logic              sys_clk,
	input  wire logic              arst_n,
	input  wire logic [6:0]        ss_pct,
	input  wire logic [12:0]       dp_mv,
	input  wire logic signed [11:0] det_err,
	input  wire logic signed [11:0] chop_err,
	ahw_src_if.prod                src
);
	if (DET_TOL < 0 || CHOP_TOL < 0)
		$error("temperature tolerance must not be negative");

	logic [3:0] nxt_ss;
	logic       nxt_dp;
	logic       nxt_det;
	logic       nxt_chop;

	always_comb
	begin
		nxt_ss   = ahw_ss_nibble(ss_pct);
		nxt_dp   = (int'(dp_mv) >= DP_MIN_MV) &&
			(int'(dp_mv) <= DP_MAX_MV);
		nxt_det  = ahw_near(det_err, DET_TOL);
		nxt_chop = ahw_near(chop_err, CHOP_TOL);
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			src.ss_nibble <= 4'h0;
			src.dp_ok     <= 1'b0;
			src.det_ok    <= 1'b0;
			src.chop_ok   <= 1'b0;
		end
		else
		begin
			src.ss_nibble <= nxt_ss;
			src.dp_ok     <= nxt_dp;
			src.det_ok    <= nxt_det;
			src.chop_ok   <= nxt_chop;
		end
	end

	a_ss_floor: assert property (@(posedge sys_clk)
		disable iff (!arst_n)
		int'(src.ss_nibble) * SS_STEP_X100 <= int'($past(ss_pct)) * SS_SCALE)
		else $error("signal strength nibble above its floor");
	a_dp_window: assert property (@(posedge sys_clk)
		disable iff (!arst_n)
		(int'($past(dp_mv)) < DP_MIN_MV) |-> !src.dp_ok)
		else $error("pressure flag set below the window");
endmodule : ahw_quant

// *** hdl/ahw_filter.sv ***
// Purpose: first order averaging of the gas signal
// Assumes: one sample per sample_valid pulse
// Notes:   a larger shift averages more and narrows the bandwidth
`timescale 1ns/1ns
module ahw_filter
	import ahw_pkg::*;
#(
	parameter int W = 16
)(
	input  wire logic                sys_clk,
	input  wire logic                arst_n,
	input  wire logic                sample_valid,
	input  wire logic signed [W-1:0] sample,
	input  wire ahw_bw_t             bw,
	output logic signed [W-1:0]      out_ff,
	output logic                     out_valid_ff
);
	if (W < 4)
		$error("filter width too small");

	logic signed [W:0]   diff;
	logic signed [W:0]   step;
	logic signed [W:0]   sum;
	logic signed [W-1:0] nxt_out;

	always_comb
	begin
		diff = {sample[W-1], sample} - {out_ff[W-1], out_ff};
		unique case (bw)
			AHW_BW_5:  step = diff >>> BW5_SHIFT;
			AHW_BW_10: step = diff >>> BW10_SHIFT;
			default:   step = diff >>> BW20_SHIFT;
		endcase
		sum = {out_ff[W-1], out_ff} + step;
		nxt_out = sample_valid ? sum[W-1:0] : out_ff;
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			out_ff       <= '0;
			out_valid_ff <= 1'b0;
		end
		else
		begin
			out_ff       <= nxt_out;
			out_valid_ff <= sample_valid;
		end
	end

	a_filter_hold: assert property (@(posedge sys_clk)
		disable iff (!arst_n)
		!sample_valid |=> $stable(out_ff))
		else $error("filter moved without a sample");
endmodule : ahw_filter

// *** hdl/ahw_top.sv ***
// Purpose: cell health word assembly, bandwidth select, AXI4-Lite slave
// Assumes: all inputs synchronous to sys_clk
// Notes:   health word is captured only on record_strobe
//
// Local design decisions: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
// How it works
// - software picks one of three bandwidths, which sets the filter averaging.
// - each bandwidth maps to a filter shift whose -3 dB point is that rate.
// - the health word is sixteen bits and never exceeds 8191.
// - bits 15 to 13 of the word always read zero.
// - bits 3 to 0 carry signal strength divided by 6.67, truncated and saturating at 15.
// - bit 4 is always one.
// - bit 5 is one only while the optical wheel is phase locked.
// - bit 6 is one while the detector temperature is near setpoint.
// - bit 7 is one while the chopper temperature is near setpoint.
// - bit 8 is one while the pressure reading is within 0.1 to 4.9 V.
// - bit 9 is one while all internal reference voltages are good.
// - bits 10 and 11 report the inlet and outlet thermocouples as sound.
// - bit 12 is one while an enclosed-path head is attached.
module ahw_top
	import ahw_pkg::*;
#(
	parameter int GAS_W    = 16,
	parameter int DET_TOL  = 50,
	parameter int CHOP_TOL = 50
)(
	input  wire logic                    sys_clk,
	input  wire logic                    arst_n,
	input  wire logic [AXI_AW-1:0]       s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [AXI_AW-1:0]       s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	input  wire logic                    record_strobe,
	input  wire logic                    pll_lock,
	input  wire logic                    ref_ok,
	input  wire logic                    tin_ok,
	input  wire logic                    tout_ok,
	input  wire logic                    head_enclosed,
	input  wire logic [6:0]              ss_pct,
	input  wire logic [12:0]             dp_mv,
	input  wire logic signed [11:0]      det_err,
	input  wire logic signed [11:0]      chop_err,
	input  wire logic                    gas_valid,
	input  wire logic signed [GAS_W-1:0] gas_sample,
	output logic [15:0]                  health_word,
	output logic                         health_valid,
	output logic signed [GAS_W-1:0]      gas_filt,
	output logic                         gas_filt_valid,
	output logic                         irq
);
	if (GAS_W < 4 || GAS_W > 32)
		$error("gas width must lie between 4 and 32");

	ahw_src_if src ();

	ahw_quant #(.DET_TOL(DET_TOL), .CHOP_TOL(CHOP_TOL)) u_quant (
		.sys_clk  (sys_clk),
		.arst_n   (arst_n),
		.ss_pct   (ss_pct),
		.dp_mv    (dp_mv),
		.det_err  (det_err),
		.chop_err (chop_err),
		.src      (src.prod)
	);

	ahw_bw_t bw_ff;
	ahw_bw_t nxt_bw;

	ahw_filter #(.W(GAS_W)) u_filter (
		.sys_clk      (sys_clk),
		.arst_n       (arst_n),
		.sample_valid (gas_valid),
		.sample       (gas_sample),
		.bw           (bw_ff),
		.out_ff       (gas_filt),
		.out_valid_ff (gas_filt_valid)
	);

	// health word
	logic [15:0] health_ff;
	logic [15:0] nxt_health;
	logic [15:0] word_now;
	logic        hvalid_ff;
	logic        pll_q_ff;

	always_comb
	begin
		word_now = 16'h0000;
		word_now[HB_SS_MSB:HB_SS_LSB] = src.ss_nibble;
		word_now[HB_SYNC] = 1'b1;
		word_now[HB_PLL]  = pll_lock;
		word_now[HB_DET]  = src.det_ok;
		word_now[HB_CHOP] = src.chop_ok;
		word_now[HB_DP]   = src.dp_ok;
		word_now[HB_REF]  = ref_ok;
		word_now[HB_TIN]  = tin_ok;
		word_now[HB_TOUT] = tout_ok;
		word_now[HB_HEAD] = head_enclosed;
		// one snapshot per record; the quantized fields lag the direct inputs by one cycle
		nxt_health = record_strobe ? word_now : health_ff;
	end

	// register file and interrupts
	logic [IRQ_W-1:0] stat_ff;
	logic [IRQ_W-1:0] nxt_stat;
	logic [IRQ_W-1:0] mask_ff;
	logic [IRQ_W-1:0] nxt_mask;
	logic [IRQ_W-1:0] events;
	logic [IRQ_W-1:0] w1c;
	logic             nxt_irq;
	logic             irq_ff;

	// write channel
	logic             aw_held_ff;
	logic             nxt_aw_held;
	logic [AXI_AW-1:0] awaddr_ff;
	logic [AXI_AW-1:0] nxt_awaddr;
	logic             w_held_ff;
	logic             nxt_w_held;
	logic [31:0]      wdata_ff;
	logic [31:0]      nxt_wdata;
	logic [3:0]       wstrb_ff;
	logic [3:0]       nxt_wstrb;
	logic             bvalid_ff;
	logic             nxt_bvalid;
	logic [1:0]       bresp_ff;
	logic [1:0]       nxt_bresp;
	logic             awready_ff;
	logic             wready_ff;
	logic             do_wr;

	// read channel
	logic             rvalid_ff;
	logic             nxt_rvalid;
	logic [31:0]      rdata_ff;
	logic [31:0]      nxt_rdata;
	logic [1:0]       rresp_ff;
	logic [1:0]       nxt_rresp;
	logic             arready_ff;

	always_comb
	begin
		nxt_aw_held = aw_held_ff;
		nxt_awaddr  = awaddr_ff;
		nxt_w_held  = w_held_ff;
		nxt_wdata   = wdata_ff;
		nxt_wstrb   = wstrb_ff;
		nxt_bvalid  = bvalid_ff;
		nxt_bresp   = bresp_ff;
		nxt_bw      = bw_ff;
		nxt_mask    = mask_ff;
		w1c         = '0;
		if (s_axi_awvalid && awready_ff)
		begin
			nxt_aw_held = 1'b1;
			nxt_awaddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_ff)
		begin
			nxt_w_held = 1'b1;
			nxt_wdata  = s_axi_wdata;
			nxt_wstrb  = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready)
			nxt_bvalid = 1'b0;
		do_wr = aw_held_ff && w_held_ff && !bvalid_ff;
		if (do_wr)
		begin
			nxt_aw_held = 1'b0;
			nxt_w_held  = 1'b0;
			nxt_bvalid  = 1'b1;
			nxt_bresp   = RESP_OKAY;
			unique case (awaddr_ff)
				ADDR_CTRL:
					// reserved code 3 is ignored so the filter never
					// sees an undefined bandwidth
					if (wstrb_ff[0] && wdata_ff[1:0] != 2'h3)
						nxt_bw = ahw_bw_t'(wdata_ff[1:0]);
				ADDR_STAT:
					if (wstrb_ff[0])
						w1c = wdata_ff[IRQ_W-1:0];
				ADDR_MASK:
					if (wstrb_ff[0])
						nxt_mask = wdata_ff[IRQ_W-1:0];
				ADDR_HEALTH, ADDR_FILT: ;
				default:
					nxt_bresp = RESP_SLVERR;
			endcase
		end
		events = '0;
		events[IRQ_REC]    = record_strobe;
		events[IRQ_FAULT]  = record_strobe &&
			((word_now & HEALTH_OK_MASK) != HEALTH_OK_MASK);
		events[IRQ_UNLOCK] = pll_q_ff && !pll_lock;
		// a new event outranks a clear in the same cycle
		nxt_stat = (stat_ff & ~w1c) | events;
		nxt_irq  = |(nxt_stat & nxt_mask);
	end

	always_comb
	begin
		nxt_rvalid = rvalid_ff;
		nxt_rdata  = rdata_ff;
		nxt_rresp  = rresp_ff;
		if (s_axi_rvalid && s_axi_rready)
			nxt_rvalid = 1'b0;
		if (s_axi_arvalid && arready_ff)
		begin
			nxt_rvalid = 1'b1;
			nxt_rresp  = RESP_OKAY;
			nxt_rdata  = 32'h0000_0000;
			unique case (s_axi_araddr)
				ADDR_HEALTH: nxt_rdata[15:0] = health_ff;
				ADDR_CTRL:   nxt_rdata[1:0]  = bw_ff;
				ADDR_STAT:   nxt_rdata[IRQ_W-1:0] = stat_ff;
				ADDR_MASK:   nxt_rdata[IRQ_W-1:0] = mask_ff;
				ADDR_FILT:   nxt_rdata = 32'(gas_filt);
				default:     nxt_rresp = RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			health_ff  <= HEALTH_RST;
			hvalid_ff  <= 1'b0;
			pll_q_ff   <= 1'b0;
			bw_ff      <= BW_RST;
			stat_ff    <= '0;
			mask_ff    <= '0;
			irq_ff     <= 1'b0;
			aw_held_ff <= 1'b0;
			awaddr_ff  <= '0;
			w_held_ff  <= 1'b0;
			wdata_ff   <= 32'h0000_0000;
			wstrb_ff   <= 4'h0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= RESP_OKAY;
			awready_ff <= 1'b0;
			wready_ff  <= 1'b0;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= 32'h0000_0000;
			rresp_ff   <= RESP_OKAY;
			arready_ff <= 1'b0;
		end
		else
		begin
			health_ff  <= nxt_health;
			hvalid_ff  <= record_strobe;
			pll_q_ff   <= pll_lock;
			bw_ff      <= nxt_bw;
			stat_ff    <= nxt_stat;
			mask_ff    <= nxt_mask;
			irq_ff     <= nxt_irq;
			aw_held_ff <= nxt_aw_held;
			awaddr_ff  <= nxt_awaddr;
			w_held_ff  <= nxt_w_held;
			wdata_ff   <= nxt_wdata;
			wstrb_ff   <= nxt_wstrb;
			bvalid_ff  <= nxt_bvalid;
			bresp_ff   <= nxt_bresp;
			awready_ff <= !nxt_aw_held && !nxt_bvalid;
			wready_ff  <= !nxt_w_held && !nxt_bvalid;
			rvalid_ff  <= nxt_rvalid;
			rdata_ff   <= nxt_rdata;
			rresp_ff   <= nxt_rresp;
			arready_ff <= !nxt_rvalid;
		end
	end

	assign health_word   = health_ff;
	assign health_valid  = hvalid_ff;
	assign irq           = irq_ff;
	assign s_axi_awready = awready_ff;
	assign s_axi_wready  = wready_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	sequence s_capture;
		record_strobe;
	endsequence
	sequence s_quiet;
		!record_strobe;
	endsequence

	a_word_max: assert property (health_ff <= HEALTH_MAX)
		else $error("health word above its maximum");
	a_unused_zero: assert property (health_ff[15:13] == 3'h0)
		else $error("unused health bits not zero");
	a_sync_one: assert property (health_ff[HB_SYNC])
		else $error("sync bit not one");
	a_pll_capture: assert property (s_capture |=>
		health_ff[HB_PLL] == $past(pll_lock))
		else $error("lock bit not taken from the wheel");
	a_det_chop: assert property (s_capture |=>
		health_ff[HB_DET] == $past(src.det_ok) &&
		health_ff[HB_CHOP] == $past(src.chop_ok))
		else $error("temperature bits not captured");
	a_chop_capture: assert property (s_capture |=>
		health_ff[HB_CHOP] == $past(src.chop_ok))
		else $error("chopper bit not captured");
	a_dp_ss_capture: assert property (s_capture |=>
		health_ff[HB_DP] == $past(src.dp_ok) &&
		health_ff[3:0] == $past(src.ss_nibble))
		else $error("pressure or strength not captured");
	a_ref_capture: assert property (s_capture |=>
		health_ff[HB_REF] == $past(ref_ok))
		else $error("reference bit not captured");
	a_thermo_pair: assert property (s_capture |=>
		health_ff[HB_TOUT:HB_TIN] == {$past(tout_ok), $past(tin_ok)})
		else $error("thermocouple bits not captured");
	a_head_capture: assert property (s_capture |=>
		health_ff[HB_HEAD] == $past(head_enclosed))
		else $error("head bit not captured");
	a_word_stands: assert property (s_quiet ##1 s_quiet |->
		$stable(health_ff) && !hvalid_ff)
		else $error("health word moved between records");
	a_bw_legal: assert property (bw_ff != 2'h3)
		else $error("reserved bandwidth code stored");
	a_irq_level: assert property (irq_ff == |(stat_ff & mask_ff))
		else $error("interrupt output does not follow status");
endmodule : ahw_top

// *** verif/ahw_logger_model.sv ***
// Purpose: data logger model that requests and reads output records
// Assumes: record_strobe is sampled on the rising edge of sys_clk
// Notes:   bounded wait for health_valid, record taken at that edge
`timescale 1ns/1ns
module ahw_logger_model
(
	input  wire logic        sys_clk,
	input  wire logic [15:0] health_word,
	input  wire logic        health_valid,
	output logic             record_strobe
);
	initial record_strobe = 1'b0;

	// callers space records far apart, well above twice the bandwidth
	task automatic grab(output logic [15:0] w, output int n);
		n = 0;
		@(posedge sys_clk);
		record_strobe <= 1'b1;
		@(posedge sys_clk);
		record_strobe <= 1'b0;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (health_valid !== 1'b1 && n < 8);
		w = health_word;
	endtask : grab
endmodule : ahw_logger_model

// *** verif/analyzer_health_status_word_test.sv ***
// Purpose: register level test of the cell health word block
// Assumes: AXI4-Lite master tasks, one record per logger call
// Notes:   expectations are built from the bit map, not read back
`timescale 1ns/1ns
module analyzer_health_status_word_test
	import ahw_pkg::*;
;
	localparam int TOL = 50;
	logic               sys_clk, arst_n, s_axi_awvalid, s_axi_awready;
	logic               s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic               s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic               s_axi_rvalid, s_axi_rready, record_strobe;
	logic               pll_lock, ref_ok, tin_ok, tout_ok, head_enclosed;
	logic               gas_valid, health_valid, gas_filt_valid, irq;
	logic [AXI_AW-1:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0]        s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]         s_axi_wstrb;
	logic [1:0]         s_axi_bresp, s_axi_rresp, rsp;
	logic [6:0]         ss_pct;
	logic [12:0]        dp_mv;
	logic signed [11:0] det_err, chop_err;
	logic signed [15:0] gas_sample, gas_filt, y_exp;
	logic [15:0]        health_word, hw;
	int                 error_cnt, num_checks, cyc, lat;

	ahw_top #(.GAS_W(16), .DET_TOL(TOL), .CHOP_TOL(TOL)) u_dut (
		.sys_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .record_strobe, .pll_lock, .ref_ok,
		.tin_ok, .tout_ok, .head_enclosed, .ss_pct, .dp_mv, .det_err,
		.chop_err, .gas_valid, .gas_sample, .health_word, .health_valid,
		.gas_filt, .gas_filt_valid, .irq);

	ahw_logger_model u_log (.sys_clk, .health_word, .health_valid,
		.record_strobe);

	always #50 sys_clk = ~sys_clk;

	// a hung handshake must still reach the verdict
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			error_cnt++;
			close_out();
		end
	end

	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : close_out

	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic axw(input logic [AXI_AW-1:0] a, input logic [31:0] d);
		bit aw_done;
		bit w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			if (!aw_done && s_axi_awready === 1'b1)
			begin
				aw_done = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_done && s_axi_wready === 1'b1)
			begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (s_axi_bvalid !== 1'b1);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axw

	task automatic rchk(input string n, input logic [AXI_AW-1:0] a,
		input logic [31:0] exp);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		chk(n, rd, exp);
	endtask : rchk

	task automatic hcase(input logic p, r, ti, tu, hd, input logic [6:0] s,
		input logic [12:0] dp, input logic signed [11:0] de, ch);
		logic [15:0] e;
		int          q;
		q = int'(s) * 100 / 667;
		e = {3'h0, hd, tu, ti, r, dp >= DP_MIN_MV && dp <= DP_MAX_MV,
			ch <= TOL && ch >= -TOL, de <= TOL && de >= -TOL, p, 1'b1,
			(q > 15) ? 4'hF : 4'(q)};
		@(posedge sys_clk);
		pll_lock <= p;
		ref_ok <= r;
		tin_ok <= ti;
		tout_ok <= tu;
		head_enclosed <= hd;
		ss_pct <= s;
		dp_mv <= dp;
		det_err <= de;
		chop_err <= ch;
		u_log.grab(hw, lat);
		chk("health_valid", 32'(lat), 32'h1);
		chk("health_hi", 32'(hw[15:13]), 32'h0);
		chk("health_max", 32'(hw <= HEALTH_MAX), 32'h1);
		chk("health_word", 32'(hw), 32'(e));
		chk("health_flags", 32'(hw[12:8]), 32'(e[12:8]));
		// inputs move after capture, the word must not follow them
		pll_lock <= ~p;
		ss_pct <= 7'h00;
		repeat (2) @(posedge sys_clk);
		chk("health_hold", 32'(health_word), 32'(e));
		rchk("health_reg", ADDR_HEALTH, 32'(e));
	endtask : hcase

	task automatic gas(input logic [1:0] bw, input logic signed [15:0] x);
		int unsigned k;
		k = (bw == 2'h0) ? BW5_SHIFT : (bw == 2'h1) ? BW10_SHIFT : BW20_SHIFT;
		@(posedge sys_clk);
		gas_sample <= x;
		gas_valid <= 1'b1;
		@(posedge sys_clk);
		gas_valid <= 1'b0;
		do @(posedge sys_clk); while (gas_filt_valid !== 1'b1);
		y_exp = y_exp + ((x - y_exp) >>> k);
		chk("gas_filt", 32'(gas_filt), 32'(y_exp));
	endtask : gas

	initial
	begin
		{sys_clk, arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, pll_lock, ref_ok, tin_ok} = '0;
		{tout_ok, head_enclosed, gas_valid, error_cnt, num_checks} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, ss_pct, dp_mv} = '0;
		{det_err, chop_err, gas_sample, y_exp, cyc} = '0;
		s_axi_wstrb = 4'hF;
		repeat (3) @(posedge sys_clk);
		chk("health_rst", 32'(health_word), 32'(HEALTH_RST));
		arst_n <= 1'b1;
		rchk("ctrl_rst", ADDR_CTRL, 32'h2);
		rchk("mask_rst", ADDR_MASK, 32'h0);
		rchk("stat_rst", ADDR_STAT, 32'h0);
		rchk("unmapped_rd", 5'h14, 32'h0);
		chk("unmapped_rresp", 32'(rsp), 32'(RESP_SLVERR));
		$display("test reset done");
		hcase(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 7'd100, 13'd2500, 12'sd0,
			12'sd0);
		hcase(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 7'd87, 13'd100, 12'sd50,
			-12'sd50);
		hcase(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 7'd6, 13'd99, 12'sd51,
			12'sd49);
		hcase(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 7'd7, 13'd4900, -12'sd51,
			12'sd51);
		hcase(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 7'd127, 13'd4901, 12'sd0,
			-12'sd51);
		$display("test health done");
		axw(ADDR_STAT, 32'h7);
		axw(ADDR_MASK, 32'h1);
		repeat (2) @(posedge sys_clk);
		chk("irq_idle", 32'(irq), 32'h0);
		// last case left flags low, so this record is degraded too
		u_log.grab(hw, lat);
		rchk("stat_rec", ADDR_STAT, 32'h3);
		chk("irq_rec", 32'(irq), 32'h1);
		axw(ADDR_STAT, 32'h1);
		rchk("stat_w1c", ADDR_STAT, 32'h2);
		chk("irq_masked", 32'(irq), 32'h0);
		@(posedge sys_clk);
		pll_lock <= 1'b1;
		@(posedge sys_clk);
		pll_lock <= 1'b0;
		rchk("stat_unlock", ADDR_STAT, 32'h6);
		axw(ADDR_MASK, 32'h4);
		repeat (2) @(posedge sys_clk);
		chk("irq_unlock", 32'(irq), 32'h1);
		axw(ADDR_STAT, 32'h6);
		rchk("stat_clr", ADDR_STAT, 32'h0);
		chk("irq_clr", 32'(irq), 32'h0);
		$display("test events done");
		for (int b = 0; b < 3; b++)
		begin
			axw(ADDR_CTRL, 32'(b));
			rchk("ctrl_bw", ADDR_CTRL, 32'(b));
			gas(2'(b), 16'sd1600);
			gas(2'(b), -16'sd800);
		end
		rchk("filt_reg", ADDR_FILT, {{16{y_exp[15]}}, y_exp});
		axw(ADDR_CTRL, 32'h3);
		rchk("ctrl_bad", ADDR_CTRL, 32'h2);
		axw(ADDR_HEALTH, 32'h0);
		chk("health_wr_resp", 32'(rsp), 32'(RESP_OKAY));
		axw(5'h18, 32'h1);
		chk("unmapped_bresp", 32'(rsp), 32'(RESP_SLVERR));
		$display("test bandwidth done");
		close_out();
	end
endmodule : analyzer_health_status_word_test
